// *** pcmb_host_bus.sv ***
/*
  parallel host bus port and control logic of a companding pcm voice codec.
  assumes strobes, select and frame sync are synchronous to mclk; the bus
  wire level is resolved outside from bus_out and bus_oe.
*/
`timescale 1ns/10ps
`default_nettype none

module pcmb_host_bus
  import pcmb_pkg::*;
#(
  parameter bit ALAW = 1'b0,
  parameter int ENC_DELAY = ENC_CYCLES,
  parameter int DEC_DELAY = DEC_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic register_select,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  input wire logic frame_sync_n,
  input wire logic signed [15:0] tx_sample,
  output logic signed [15:0] receive_amp_output,
  output logic receive_amp_enable,
  output pcmb_mode_t mode,
  output logic running
);

  localparam int CW = $clog2((ENC_DELAY > DEC_DELAY ? ENC_DELAY : DEC_DELAY) + 1);
  localparam logic [CW-1:0] ENC_LOAD = CW'(ENC_DELAY);
  localparam logic [CW-1:0] DEC_LOAD = CW'(DEC_DELAY);
  localparam logic [CW-1:0] ONE = CW'(1);

  pcmb_ctrl_t ctrl_q;
  pcmb_state_t state_q, state_d;
  logic rd_q, wr_q, fs_q, wr_sel_q, rd_sel_q;
  logic seen_rd_q, seen_wr_q;
  logic [7:0] wr_data_q, rx_reg_q, tx_reg_q, dec_code_q, bus_out_q;
  logic signed [15:0] enc_sample_q, rx_linear_q;
  logic [CW-1:0] enc_cnt_q, dec_cnt_q;
  logic [7:0] code_out, inv_mask, wr_code, rx_bus, tx_bus, ctrl_read, read_val;
  logic signed [15:0] lin_out;
  logic wr_end, rd_end, fs_fall, ctrl_wr, pcm_wr, pcm_rd, loop_drive;
  logic enc_done, dec_done, dig_loop, ana_loop, even_inv;
  pcmb_rate_t rate_sel;
  pcmb_loop_t loop_sel;

  ////////////////////////////////////////////////////////////////////////////
  // strobe and frame edges
  assign wr_end = wr_q & ~wr_strobe;
  assign rd_end = rd_q & ~rd_strobe;
  assign fs_fall = fs_q & ~frame_sync_n;
  assign ctrl_wr = wr_end & (wr_sel_q == SEL_CONTROL);
  assign pcm_wr = wr_end & (wr_sel_q != SEL_CONTROL);
  assign pcm_rd = rd_end & (rd_sel_q != SEL_CONTROL);

  // mode decode
  assign dig_loop = ctrl_q.digital_loop_bit;
  assign ana_loop = ~ctrl_q.digital_loop_bit & ctrl_q.analog_loop_bit;
  assign rate_sel = !ctrl_q.clock_select_low ? RATE_1024K :
                    (ctrl_q.clock_select_high ? RATE_1280K : RATE_768K);
  assign loop_sel = dig_loop ? LOOP_DIGITAL :
                    (ana_loop ? LOOP_ANALOG : LOOP_NORMAL);
  assign even_inv = ALAW & ~ctrl_q.alaw_inversion_bit;
  assign mode = '{clock_rate: rate_sel, loop_mode: loop_sel,
                  power_down: ctrl_q.power_down_bit, even_invert: even_inv};
  assign inv_mask = even_inv ? ALAW_EVEN_INV : 8'h00;

  // bus line i carries code bit 7-i for pcm, control bit i for control
  for (genvar i = 0; i < 8; i++) begin : g_bitrev
    assign wr_code[i] = wr_data_q[7 - i];
    assign rx_bus[i] = rx_reg_q[7 - i];
    assign tx_bus[i] = tx_reg_q[7 - i];
  end

  // readback and output selection
  assign ctrl_read = {SPARE_READ, ALAW ? ctrl_q.alaw_inversion_bit : 1'b1,
                      ctrl_q[4:0]};
  assign loop_drive = wr_strobe & (register_select != SEL_CONTROL) & dig_loop;
  assign read_val = loop_drive ? rx_bus :
                    ((register_select == SEL_CONTROL) ? ctrl_read : tx_bus);
  assign bus_oe = ~rst & (rd_strobe | loop_drive);
  assign bus_out = bus_out_q;

  assign enc_done = (enc_cnt_q == ONE);
  assign dec_done = (dec_cnt_q == ONE);
  assign running = (state_q == ST_RUN);
  assign receive_amp_output = rx_linear_q;
  assign receive_amp_enable = (state_q != ST_POWERDOWN);

  ////////////////////////////////////////////////////////////////////////////
  // bus side registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wr_sel_q <= 1'b0;
      rd_sel_q <= 1'b0;
      wr_data_q <= 8'h00;
      bus_out_q <= 8'h00;
    end else begin
      rd_q <= rd_strobe;
      wr_q <= wr_strobe;
      if (wr_strobe) wr_sel_q <= register_select;
      if (wr_strobe) wr_data_q <= bus_in;
      if (rd_strobe) rd_sel_q <= register_select;
      bus_out_q <= read_val;
    end
  end

  // control register, written at strobe end in any power state
  always_ff @(posedge mclk) begin
    if (rst) ctrl_q <= pcmb_ctrl_t'({2'h0, CTRL_RESET});
    else if (ctrl_wr) ctrl_q <= pcmb_ctrl_t'({2'h0, wr_data_q[5:0]});
  end

  // receive byte holds the last pcm write
  always_ff @(posedge mclk) begin
    if (rst) rx_reg_q <= 8'hFF;
    else if (pcm_wr) rx_reg_q <= wr_code;
  end

  // access flags; a new access wins over the power-down clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      seen_rd_q <= 1'b0;
      seen_wr_q <= 1'b0;
    end else begin
      seen_rd_q <= pcm_rd | (seen_rd_q & ~ctrl_q.power_down_bit);
      seen_wr_q <= pcm_wr | (seen_wr_q & ~ctrl_q.power_down_bit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POWERDOWN: if (!ctrl_q.power_down_bit) state_d = ST_STANDBY;
      ST_STANDBY: begin
        if (ctrl_q.power_down_bit) state_d = ST_POWERDOWN;
        else if (seen_rd_q && seen_wr_q) state_d = ST_RUN;
      end
      ST_RUN: if (ctrl_q.power_down_bit) state_d = ST_POWERDOWN;
      default: state_d = ST_POWERDOWN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) state_q <= ST_POWERDOWN;
    else state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // codec frame timing, driven only by frame sync
  always_ff @(posedge mclk) begin
    if (rst) begin
      fs_q <= 1'b1;
      dec_code_q <= 8'hFF;
      enc_sample_q <= 16'sh0000;
      enc_cnt_q <= '0;
      dec_cnt_q <= '0;
    end else begin
      fs_q <= frame_sync_n;
      if (fs_fall && running) begin
        dec_code_q <= rx_reg_q ^ inv_mask;
        enc_sample_q <= ana_loop ? rx_linear_q : tx_sample;
        enc_cnt_q <= ENC_LOAD;
        dec_cnt_q <= DEC_LOAD;
      end else begin
        if (enc_cnt_q != '0) enc_cnt_q <= enc_cnt_q - ONE;
        if (dec_cnt_q != '0) dec_cnt_q <= dec_cnt_q - ONE;
      end
    end
  end

  // results leave the coder at the end of each delay
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_reg_q <= 8'hFF;
      rx_linear_q <= 16'sh0000;
    end else begin
      if (enc_done) tx_reg_q <= code_out ^ inv_mask;
      if (!running) rx_linear_q <= 16'sh0000;
      else if (dec_done) rx_linear_q <= dig_loop ? 16'sh0000 : lin_out;
    end
  end

  // companding coder and expander
  pcmb_law #(.ALAW(ALAW)) u_law (
    .mclk(mclk),
    .rst(rst),
    .lin_in(enc_sample_q),
    .code_in(dec_code_q),
    .code_out_q(code_out),
    .lin_out_q(lin_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_rate_decode: assert property (
    ctrl_q.clock_select_low && !ctrl_q.clock_select_high |-> mode.clock_rate == RATE_768K)
    else $error("clock rate decode wrong");
  chk_loop_decode: assert property (
    ctrl_q.digital_loop_bit |-> mode.loop_mode == LOOP_DIGITAL)
    else $error("digital loopback not selected");
  chk_ctrl_write: assert property (
    ctrl_wr |=> ctrl_q[5:0] == $past(wr_data_q[5:0]) ##1 $stable(ctrl_q) || ctrl_wr)
    else $error("control write not latched");
  chk_readback_ones: assert property (
    rd_strobe && register_select == SEL_CONTROL |=>
      bus_out_q[7:6] == 2'h3 && (ALAW || bus_out_q[5]))
    else $error("spare bits not read as one");
  chk_rx_hold: assert property (
    !(fs_fall && running) |=> $stable(dec_code_q))
    else $error("decoder code changed outside frame sync");
  chk_enc_start: assert property (
    fs_fall && running |=> enc_cnt_q == ENC_LOAD ##1 enc_cnt_q == ENC_LOAD - ONE)
    else $error("encode delay not started");
  chk_dig_idle: assert property (
    dec_done && dig_loop && running |=> rx_linear_q == 16'sh0000)
    else $error("digital loopback receive not idle");
  chk_powerdown_float: assert property (
    $rose(ctrl_q.power_down_bit) |=> !receive_amp_enable && !running)
    else $error("receive output driven while powered down");
  chk_start_gate: assert property (
    $rose(running) |-> $past(seen_rd_q) && $past(seen_wr_q) && !$past(ctrl_q.power_down_bit))
    else $error("coding started without pcm accesses");
  chk_loop_drive: assert property (
    wr_strobe && register_select != SEL_CONTROL && dig_loop |-> bus_oe ##1 bus_out_q == $past(rx_bus))
    else $error("loopback byte not driven");

  // storage and timing checks
  chk_rx_steady: assert property (
    running && !dec_done |=> $stable(rx_linear_q))
    else $error("receive output changed before decode delay end");
  chk_tx_steady: assert property (
    !enc_done |=> $stable(tx_reg_q))
    else $error("transmit byte changed before encode delay end");
  chk_rx_quiet: assert property (
    !running |=> rx_linear_q == 16'sh0000)
    else $error("receive output active while not coding");
  chk_ctrl_hold: assert property (
    !ctrl_wr |=> $stable(ctrl_q))
    else $error("control register changed without a write");
  chk_rx_store: assert property (
    !pcm_wr |=> $stable(rx_reg_q))
    else $error("receive byte changed without a pcm write");
  chk_bus_quiet: assert property (
    !rd_strobe && !wr_strobe |-> !bus_oe)
    else $error("bus driven without a strobe");
  chk_seen_clear: assert property (
    ctrl_q.power_down_bit && !pcm_rd |=> !seen_rd_q)
    else $error("read flag kept while powered down");
  chk_enc_capture: assert property (
    fs_fall && running && ana_loop |=> enc_sample_q == $past(rx_linear_q))
    else $error("analog loop sample not fed to encoder");
  chk_dec_capture: assert property (
    fs_fall && running |=> dec_code_q[7] == $past(rx_reg_q[7]))
    else $error("receive byte not passed to decoder");

  cov_ctrl_write: cover property (ctrl_wr ##1 !ctrl_q.power_down_bit);
  cov_frame_run: cover property (fs_fall && running);
  cov_loop_drive: cover property (loop_drive ##1 bus_oe);
  cov_analog_frame: cover property (fs_fall && running && ana_loop);
  cov_power_down: cover property ($rose(ctrl_q.power_down_bit));

endmodule // pcmb_host_bus

`default_nettype wire

// *** pcmb_pkg.sv ***
/*
  package for the codec host bus and control logic: control register layout,
  reset values, mode enumerations and timing constants.
  assumes a 100 MHz system clock.
*/
package pcmb_pkg;

  // control register bit positions, bus line 0 carries bit 0
  localparam int CTRL_CLK_LO = 0;
  localparam int CTRL_CLK_HI = 1;
  localparam int CTRL_DLOOP = 2;
  localparam int CTRL_ALOOP = 3;
  localparam int CTRL_PDOWN = 4;
  localparam int CTRL_ALAW = 5;

  // stored control bits after reset: powered down, everything else clear
  localparam logic [5:0] CTRL_RESET = 6'h10;
  // bits that always read back as one
  localparam logic [1:0] SPARE_READ = 2'h3;

  // register_select level that addresses the control register
  localparam logic SEL_CONTROL = 1'b1;

  // even-bit inversion pattern for a-law codes
  localparam logic [7:0] ALAW_EVEN_INV = 8'h55;

  // timing, figures in microseconds and the derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int ENC_DELAY_US = 290;
  localparam int DEC_DELAY_US = 170;
  localparam int ENC_CYCLES = ENC_DELAY_US * CLK_MHZ;
  localparam int DEC_CYCLES = DEC_DELAY_US * CLK_MHZ;

  typedef struct packed {
    logic [1:0] spare_control_bits;
    logic alaw_inversion_bit;
    logic power_down_bit;
    logic analog_loop_bit;
    logic digital_loop_bit;
    logic clock_select_high;
    logic clock_select_low;
  } pcmb_ctrl_t;

  typedef enum logic [1:0] {RATE_1024K, RATE_768K, RATE_1280K} pcmb_rate_t;
  typedef enum logic [1:0] {LOOP_NORMAL, LOOP_DIGITAL, LOOP_ANALOG} pcmb_loop_t;
  typedef enum logic [1:0] {ST_POWERDOWN, ST_STANDBY, ST_RUN} pcmb_state_t;

  // mode outputs travelling together to the analog section
  typedef struct packed {
    pcmb_rate_t clock_rate;
    pcmb_loop_t loop_mode;
    logic power_down;
    logic even_invert;
  } pcmb_mode_t;

endpackage

// *** pcmb_law.sv ***
/*
  companding coder and expander, mu-255 or a-law by parameter.
  assumes codes without any a-law even-bit inversion; outputs are registered.
*/
`timescale 1ns/10ps
`default_nettype none

module pcmb_law
  import pcmb_pkg::*;
#(
  parameter bit ALAW = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic signed [15:0] lin_in,
  input wire logic [7:0] code_in,
  output logic [7:0] code_out_q,
  output logic signed [15:0] lin_out_q
);

  logic [7:0] code_d;
  logic signed [15:0] lin_d;

  ////////////////////////////////////////////////////////////////////////////
  // compress a linear sample into an 8-bit code
  always_comb begin
    logic neg;
    logic [15:0] mag;
    logic [12:0] biased;
    logic [11:0] amag;
    logic [2:0] seg;
    logic [3:0] mant;
    neg = lin_in[15];
    mag = neg ? 16'(-lin_in) : 16'(lin_in);
    biased = 13'h0000;
    amag = 12'h000;
    seg = 3'h0;
    mant = 4'h0;
    code_d = 8'h00;
    if (!ALAW) begin
      biased = (mag[15:2] > 14'h1FDE) ? 13'h1FFF : 13'(mag[15:2] + 14'h0021);
      for (int i = 0; i < 8; i++) begin
        if (biased[i + 5]) seg = 3'(i);
      end
      mant = 4'(biased >> (4'(seg) + 4'h1)); // top segment needs a shift of eight
      code_d = ~{neg, seg, mant};
    end else begin
      amag = (mag[15:3] > 13'h0FFF) ? 12'hFFF : mag[14:3]; // 12-bit magnitude, clipped
      for (int i = 0; i < 7; i++) begin
        if (amag[i + 5]) seg = 3'(i + 1);
      end
      mant = (seg == 3'h0) ? amag[4:1] : 4'(amag >> seg);
      code_d = {~neg, seg, mant};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expand an 8-bit code back into a linear sample
  always_comb begin
    logic [7:0] c;
    logic [15:0] t;
    c = ALAW ? code_in : ~code_in;
    t = 16'h0000;
    lin_d = 16'sh0000;
    if (!ALAW) begin
      t = 16'((({12'h000, c[3:0]} << 3) + 16'h0084) << c[6:4]);
      lin_d = c[7] ? 16'(16'sh0084 - $signed(t)) : 16'($signed(t) - 16'sh0084);
    end else begin
      if (c[6:4] == 3'h0) t = 16'(({12'h000, c[3:0]} << 4) + 16'h0008);
      else t = 16'((({12'h000, c[3:0]} << 4) + 16'h0108) << (c[6:4] - 3'h1));
      lin_d = c[7] ? $signed(t) : 16'(-$signed(t));
    end
  end

  // registered results
  always_ff @(posedge mclk) begin
    if (rst) begin
      code_out_q <= 8'hFF;
      lin_out_q <= 16'sh0000;
    end else begin
      code_out_q <= code_d;
      lin_out_q <= lin_d;
    end
  end

endmodule // pcmb_law

`default_nettype wire

// *** pcmb_host_model.sv ***
/*
  host side partner for the codec host port: strobes, register select,
  frame sync and the resolved level of the parallel bus wire.
  assumes the port drives bus_out whenever bus_oe is high.
*/
`timescale 1ns/10ps
`default_nettype none

module pcmb_host_model (
  input wire logic mclk,
  input wire logic bus_oe,
  input wire logic [7:0] bus_out,
  output logic [7:0] bus_in,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic register_select,
  output logic frame_sync_n
);
  logic [7:0] drv = 8'hA5;

  // idle levels from time zero
  initial begin
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    register_select = 1'b1;
    frame_sync_n = 1'b1;
  end

  // wire level: device drive wins, else host drive or released pattern
  assign bus_in = bus_oe ? bus_out : drv;

  // write cycle; select settles a cycle ahead of the strobe
  task automatic write_reg(input logic sel, input logic [7:0] d, output logic oe,
                           output logic [7:0] seen);
    @(posedge mclk) #1;
    register_select = sel;
    @(posedge mclk) #1;
    drv = d;
    wr_strobe = 1'b1;
    @(posedge mclk);
    @(posedge mclk) #1;
    oe = bus_oe;
    seen = bus_out;
    wr_strobe = 1'b0;
    @(posedge mclk) #1;
    drv = ~d; // released bus shows the inverse of the last value
    @(posedge mclk) #1;
    @(posedge mclk) #1;
  endtask

  // read cycle; data taken from the wire while the device drives it
  task automatic read_reg(input logic sel, output logic [7:0] d);
    @(posedge mclk) #1;
    register_select = sel;
    @(posedge mclk) #1;
    rd_strobe = 1'b1;
    @(posedge mclk);
    @(posedge mclk) #1;
    d = bus_in;
    rd_strobe = 1'b0;
    @(posedge mclk) #1;
  endtask

  // one frame sync pulse, never overlapping a bus access
  task automatic frame_pulse();
    @(posedge mclk) #1;
    frame_sync_n = 1'b0;
    @(posedge mclk) #1;
    frame_sync_n = 1'b1;
  endtask
endmodule // pcmb_host_model

`default_nettype wire

// *** tb.sv ***
/*
  self-checking bench for the codec host port, a-law build.
  assumes pcmb_pkg and the host partner model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb
  import pcmb_pkg::*;
;
  localparam int ENC_D = 20;
  localparam int DEC_D = 12;
  localparam logic SEL_PCM = ~SEL_CONTROL;
  logic mclk;
  logic rst;
  logic rd_strobe;
  logic wr_strobe;
  logic register_select;
  logic frame_sync_n;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic bus_oe;
  logic signed [15:0] tx_sample;
  logic signed [15:0] rx_out;
  logic rx_en;
  logic running;
  pcmb_mode_t mode;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] rd_v;
  logic oe_v;
  logic [7:0] seen_v;
  logic [7:0] ctl_tab [5] = '{8'h02, 8'h09, 8'h2F, 8'h14, 8'h3C};
  logic [5:0] mode_tab [5] = '{6'h01, 6'h19, 6'h24, 6'h07, 6'h06};

  pcmb_host_bus #(.ALAW(1'b1), .ENC_DELAY(ENC_D), .DEC_DELAY(DEC_D)) pcmb_host_bus_inst (
    .mclk(mclk), .rst(rst), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .register_select(register_select), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .frame_sync_n(frame_sync_n), .tx_sample(tx_sample), .receive_amp_output(rx_out),
    .receive_amp_enable(rx_en), .mode(mode), .running(running));

  pcmb_host_model pcmb_host_model_inst (
    .mclk(mclk), .bus_oe(bus_oe), .bus_out(bus_out), .bus_in(bus_in), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .register_select(register_select), .frame_sync_n(frame_sync_n));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      $display("[FAIL] timeout expected done seen hang");
      end_sim();
    end
  end

  function automatic logic [7:0] rev(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = v[7 - i];
    return r;
  endfunction

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic sel, input logic [7:0] d);
    pcmb_host_model_inst.write_reg(sel, d, oe_v, seen_v);
  endtask

  task automatic rd(input logic sel);
    pcmb_host_model_inst.read_reg(sel, rd_v);
  endtask

  task automatic frame_wait(input int n);
    pcmb_host_model_inst.frame_pulse();
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    tx_sample = -16'sd20000;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    check8("bus_oe idle", 8'h00, {7'h0, bus_oe});
    check8("rx enable", 8'h00, {7'h0, rx_en});
    rd(SEL_CONTROL);
    check8("ctrl reset", 8'hD0, rd_v);
    $display("test reset done");
    foreach (ctl_tab[i]) begin
      wr(SEL_CONTROL, ctl_tab[i]);
      check8("mode", {2'h0, mode_tab[i]}, {2'h0, mode});
      check8("rx enable", {7'h0, ~ctl_tab[i][4]}, {7'h0, rx_en});
      rd(SEL_CONTROL);
      check8("ctrl readback", ctl_tab[i] | 8'hC0, rd_v);
    end
    $display("test modes done");
    // coding starts only after a pcm read and a pcm write
    wr(SEL_CONTROL, 8'h20);
    frame_wait(DEC_D + 3);
    check8("running early", 8'h00, {7'h0, running});
    check8("rx idle", 8'h00, {6'h0, rx_out[15], |rx_out});
    rd(SEL_PCM);
    check8("tx reset", 8'hFF, rd_v);
    wr(SEL_PCM, rev(8'hF0));
    check8("running", 8'h01, {7'h0, running});
    frame_wait(DEC_D - 1);
    check8("rx before delay", 8'h00, {6'h0, rx_out[15], |rx_out});
    repeat (4) @(posedge mclk);
    #1;
    check8("rx positive", 8'h01, {6'h0, rx_out[15], |rx_out});
    rd(SEL_PCM);
    check8("tx before delay", 8'hFF, rd_v);
    repeat (2) @(posedge mclk);
    #1;
    rd(SEL_PCM);
    check8("tx sign", 8'h00, {7'h0, rd_v[0]});
    wr(SEL_PCM, rev(8'h70));
    check8("rx held", 8'h01, {6'h0, rx_out[15], |rx_out});
    tx_sample = 16'sd20000;
    frame_wait(DEC_D + 3);
    check8("rx negative", 8'h03, {6'h0, rx_out[15], |rx_out});
    $display("test frames done");
    // analog loop: encoder sees the negative receive sample
    wr(SEL_CONTROL, 8'h28);
    frame_wait(ENC_D + 3);
    rd(SEL_PCM);
    check8("aloop tx sign", 8'h00, {7'h0, rd_v[0]});
    check8("aloop rx enable", 8'h01, {7'h0, rx_en});
    // digital loop: held byte driven back during the pcm write
    wr(SEL_CONTROL, 8'h24);
    wr(SEL_PCM, 8'h5A);
    check8("dloop oe", 8'h01, {7'h0, oe_v});
    check8("dloop data", rev(8'h70), seen_v);
    frame_wait(DEC_D + 3);
    check8("dloop rx idle", 8'h00, {6'h0, rx_out[15], |rx_out});
    $display("test loops done");
    wr(SEL_CONTROL, 8'h30);
    check8("pd running", 8'h00, {6'h0, running, rx_en});
    rd(SEL_CONTROL);
    check8("pd readback", 8'hF0, rd_v);
    $display("test power down done");
    // reset again in standby: defaults return
    wr(SEL_CONTROL, 8'h01);
    check8("up before reset", 8'h01, {7'h0, rx_en});
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    check8("reset again", 8'h00, {6'h0, running, rx_en});
    check8("reset again oe", 8'h00, {7'h0, bus_oe});
    rd(SEL_CONTROL);
    check8("ctrl after reset", 8'hD0, rd_v);
    $display("test reset again done");
    end_sim();
  end
endmodule // tb

`default_nettype wire
